/* File: sctm_pkg.sv */
// sctm_pkg: shared constants and types of the synchronous dram command and timing block
// assumes a single pclk domain at 50 MHz; the apb slave and the memory pins share it
package sctm_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;        // pclk period
   localparam int MODE_GAP_CYC = 2;          // cycles from mode load to next command
   localparam int RD_MASK_LAT = 2;           // read mask latency in cycles
   localparam int WR_MASK_LAT = 0;           // write mask latency in cycles
   localparam int TRAIL_CL3 = 2;             // words still driven after a cut, latency 3
   localparam int TRAIL_CL2 = 1;             // words still driven after a cut, latency 2

   // ----------------------------------------------------------------
   // apb register map
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFF = 8'h00;  // read latency and burst length
   localparam logic [7:0] STAT_OFF = 8'h04;  // bank and power state
   localparam logic [7:0] ERR_OFF = 8'h08;   // sticky misuse flags, write one to clear
   localparam int CTRL_LAT_POS = 0;          // 1 = latency 3, 0 = latency 2
   localparam int CTRL_BL_POS = 1;           // three bit burst length code
   localparam logic [3:0] CTRL_RST = 4'h5;   // latency 3, burst of four
   localparam int STAT_PWR_POS = 4;          // power state field, three bits
   localparam int ERR_MODE_POS = 0;          // mode load with a bank open
   localparam int ERR_REF_POS = 1;           // refresh with a bank open
   localparam int ERR_GAP_POS = 2;           // command inside the mode load gap

   // burst length codes
   localparam logic [2:0] BL_1 = 3'h0;
   localparam logic [2:0] BL_2 = 3'h1;
   localparam logic [2:0] BL_4 = 3'h2;
   localparam logic [2:0] BL_8 = 3'h3;
   localparam logic [2:0] BL_PAGE = 3'h7;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [7:0] {
      CMD_NOP = 8'h01, CMD_MODE = 8'h02, CMD_ACT = 8'h04, CMD_READ = 8'h08,
      CMD_WRITE = 8'h10, CMD_STOP = 8'h20, CMD_PRE = 8'h40, CMD_REF = 8'h80
   } sctm_cmd_t;

   typedef enum logic [2:0] {
      PWR_RUN = 3'h1, PWR_SUSPEND = 3'h2, PWR_DOWN = 3'h4
   } sctm_pwr_t;

endpackage : sctm_pkg

/* File: sctm_core.sv */
// sctm_core: command decode, bank state, burst engine and data masking of a four bank
// synchronous dram, with an apb slave for latency, burst length and status.
// assumes all pins synchronous to pclk; the host keeps its own command spacing.
`timescale 1ns/1ps
module sctm_core #(
   parameter int COL_W = 8,         // column address width
   parameter int MEM_DEPTH = 16,    // words of storage held in flip-flops
   parameter int DATA_W = 16        // data pin width
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // memory command pins
   input wire logic device_select_n,
   input wire logic row_strobe_n,
   input wire logic column_strobe_n,
   input wire logic write_strobe_n,
   input wire logic clock_gate,
   input wire logic data_mask,
   input wire logic [1:0] memory_group_select,
   input wire logic precharge_all_flag,
   input wire logic [COL_W-1:0] address,
   // data pins
   input wire logic [DATA_W-1:0] dq_in,
   output logic [DATA_W-1:0] dq_out,
   output logic dq_oe,
   // state
   output logic [3:0] bank_open,
   output logic [2:0] power_state
);

   localparam int IDX_W = $clog2(MEM_DEPTH);

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   // strobe pattern to command
   function automatic sctm_pkg::sctm_cmd_t cmd_decode(input logic ras_n, input logic cas_n,
                                                      input logic we_n);
      unique case ({ras_n, cas_n, we_n})
         3'h0: cmd_decode = sctm_pkg::CMD_MODE;
         3'h3: cmd_decode = sctm_pkg::CMD_ACT;
         3'h5: cmd_decode = sctm_pkg::CMD_READ;
         3'h4: cmd_decode = sctm_pkg::CMD_WRITE;
         3'h6: cmd_decode = sctm_pkg::CMD_STOP;
         3'h2: cmd_decode = sctm_pkg::CMD_PRE;
         3'h1: cmd_decode = sctm_pkg::CMD_REF;
         3'h7: cmd_decode = sctm_pkg::CMD_NOP;
      endcase
   endfunction : cmd_decode

   // select bits to bank index: bit0 weighs two, bit1 weighs one
   function automatic logic [1:0] bank_index(input logic [1:0] sel);
      bank_index = {sel[0], sel[1]};
   endfunction : bank_index

   // burst length code to remaining words after the first
   function automatic logic [8:0] burst_rest(input logic [2:0] code);
      unique case (code)
         sctm_pkg::BL_2: burst_rest = 9'h001;
         sctm_pkg::BL_4: burst_rest = 9'h003;
         sctm_pkg::BL_8: burst_rest = 9'h007;
         sctm_pkg::BL_PAGE: burst_rest = 9'h1FF;
         default: burst_rest = 9'h000;
      endcase
   endfunction : burst_rest

   // ----------------------------------------------------------------
   // registers and nets
   // ----------------------------------------------------------------
   logic [3:0] ctrl_r;                    // latency select and burst length code
   logic [2:0] err_r;                     // sticky misuse flags
   logic cke_prev_r;                      // clock gate seen at the previous edge
   logic [1:0] mode_gap_r;                // blocks commands after a mode load
   logic [3:0] bank_open_r;               // one bit per open bank
   sctm_pkg::sctm_pwr_t pwr_r;            // run, suspend or power-down
   logic [8:0] bst_left_r;                // words left in the running burst
   logic [COL_W-1:0] bst_col_r;           // next column of the burst
   logic bst_write_r;                     // burst direction
   logic bst_ap_r;                        // auto-precharge at burst end
   logic [1:0] bst_bank_r;                // bank of the burst
   logic [DATA_W-1:0] mem_r [MEM_DEPTH];  // data storage
   logic [1:0] rd_v_r;                    // read pipe valid stages
   logic [DATA_W-1:0] rd_d_r [2];         // read pipe data stages
   logic dqm_d1_r;                        // mask delayed one cycle
   logic [DATA_W-1:0] dq_out_r;
   logic dq_oe_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;

   sctm_pkg::sctm_cmd_t cmd;              // decoded command
   logic cmd_live;                        // device selected and clock gate was high
   logic cmd_ok;                          // command acted upon
   logic is_mode, is_act, is_rd, is_wr, is_stop, is_pre, is_ref;
   logic [1:0] bank;                      // addressed bank
   logic pre_hits;                        // precharge reaches the burst bank
   logic bst_on;                          // burst advancing this cycle
   logic term;                            // burst cut this cycle
   logic rd_req;                          // a read word is fetched this cycle
   logic wr_take;                         // a write word is taken this cycle
   logic [COL_W-1:0] col_now;             // column used this cycle
   logic [IDX_W-1:0] col_idx;             // storage index of that column
   logic cl3;                             // latency three selected
   logic bst_last;                        // final word of a non-page burst
   logic apb_setup;                       // apb setup phase
   logic [31:0] rd_mux;                   // apb read value

   // ----------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------
   // a deselected device or a held clock gate yields no command
   always_comb begin
      cmd = cmd_decode(row_strobe_n, column_strobe_n, write_strobe_n);
      cmd_live = cke_prev_r && !device_select_n;
      cmd_ok = cmd_live && (mode_gap_r == 2'h0);
      is_mode = cmd_ok && (cmd == sctm_pkg::CMD_MODE);
      is_act = cmd_ok && (cmd == sctm_pkg::CMD_ACT);
      is_rd = cmd_ok && (cmd == sctm_pkg::CMD_READ);
      is_wr = cmd_ok && (cmd == sctm_pkg::CMD_WRITE);
      is_stop = cmd_ok && (cmd == sctm_pkg::CMD_STOP);
      is_pre = cmd_ok && (cmd == sctm_pkg::CMD_PRE);
      is_ref = cmd_ok && (cmd == sctm_pkg::CMD_REF);
      bank = bank_index(memory_group_select);
      cl3 = ctrl_r[sctm_pkg::CTRL_LAT_POS];
   end

   // burst control: stop, precharge of its bank, or a new column command cuts it
   always_comb begin
      pre_hits = is_pre && (precharge_all_flag || (bank == bst_bank_r));
      bst_on = cke_prev_r && (bst_left_r != 9'h000);
      term = is_stop || pre_hits || is_rd || is_wr;
      rd_req = is_rd || (bst_on && !bst_write_r && !term);
      wr_take = is_wr || (bst_on && bst_write_r && !term);
      col_now = (is_rd || is_wr) ? address : bst_col_r;
      col_idx = col_now[IDX_W-1:0];
      bst_last = (bst_left_r == 9'h001) &&
                 (ctrl_r[sctm_pkg::CTRL_BL_POS +: 3] != sctm_pkg::BL_PAGE);
   end

   // ----------------------------------------------------------------
   // clock gate and power state
   // ----------------------------------------------------------------
   // previous clock gate, used to qualify commands and freeze bursts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cke_prev_r <= 1'b1;
      end else if (clk_en) begin
         cke_prev_r <= clock_gate;
      end
   end

   // falling gate enters suspend or power-down, rising gate leaves it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr_r <= sctm_pkg::PWR_RUN;
      end else if (clk_en) begin
         if (cke_prev_r && !clock_gate) begin
            pwr_r <= (bank_open_r != 4'h0) ? sctm_pkg::PWR_SUSPEND : sctm_pkg::PWR_DOWN;
         end else if (!cke_prev_r && clock_gate) begin
            pwr_r <= sctm_pkg::PWR_RUN;
         end
      end
   end

   // mode load gap: the next command is taken two edges after the mode load
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_gap_r <= 2'h0;
      end else if (clk_en) begin
         if (is_mode) begin
            mode_gap_r <= 2'(sctm_pkg::MODE_GAP_CYC - 1);
         end else if (mode_gap_r != 2'h0) begin
            mode_gap_r <= mode_gap_r - 2'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // bank state
   // ----------------------------------------------------------------
   // activate opens, precharge and auto-precharge close, refresh leaves all idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bank_open_r <= 4'h0;
      end else if (clk_en) begin
         if (is_ref) begin
            bank_open_r <= 4'h0;
         end else if (is_pre && precharge_all_flag) begin
            bank_open_r <= 4'h0;
         end else begin
            if (bst_on && bst_ap_r && bst_last && !term) begin
               bank_open_r[bst_bank_r] <= 1'b0;
            end
            if ((is_rd || is_wr) && precharge_all_flag &&
                burst_rest(ctrl_r[sctm_pkg::CTRL_BL_POS +: 3]) == 9'h000) begin
               bank_open_r[bank] <= 1'b0;                               // single word auto-precharge
            end
            if (is_pre) begin
               bank_open_r[bank] <= 1'b0;
            end
            if (is_act) begin
               bank_open_r[bank] <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // burst engine
   // ----------------------------------------------------------------
   // loads on a column command, steps each running cycle, frozen while gated
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bst_left_r <= 9'h000;
         bst_col_r <= '0;
         bst_write_r <= 1'b0;
         bst_ap_r <= 1'b0;
         bst_bank_r <= 2'h0;
      end else if (clk_en) begin
         if (is_rd || is_wr) begin
            bst_left_r <= burst_rest(ctrl_r[sctm_pkg::CTRL_BL_POS +: 3]);
            bst_col_r <= address + COL_W'(1);
            bst_write_r <= is_wr;
            bst_ap_r <= precharge_all_flag;
            bst_bank_r <= bank;
         end else if (term) begin
            bst_left_r <= 9'h000;
         end else if (bst_on) begin
            if (ctrl_r[sctm_pkg::CTRL_BL_POS +: 3] != sctm_pkg::BL_PAGE) begin
               bst_left_r <= bst_left_r - 9'h001;
            end
            bst_col_r <= bst_col_r + COL_W'(1);
         end
      end
   end

   // write storage: a mask high at the edge blocks that word
   always_ff @(posedge pclk) begin
      if (clk_en && wr_take && !data_mask) begin
         mem_r[col_idx] <= dq_in;
      end
   end

   // ----------------------------------------------------------------
   // read pipe and output
   // ----------------------------------------------------------------
   // words fetched before a cut stay in the pipe and still leave
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_v_r <= 2'h0;
         rd_d_r[0] <= '0;
         rd_d_r[1] <= '0;
      end else if (clk_en) begin
         rd_v_r <= {rd_v_r[0], rd_req};
         rd_d_r[0] <= mem_r[col_idx];
         rd_d_r[1] <= rd_d_r[0];
      end
   end

   // mask delayed so that it blanks the word two cycles after it is sampled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dqm_d1_r <= 1'b0;
      end else if (clk_en) begin
         dqm_d1_r <= data_mask;
      end
   end

   // output stage: latency three takes the later pipe stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dq_out_r <= '0;
         dq_oe_r <= 1'b0;
      end else if (clk_en) begin
         dq_out_r <= cl3 ? rd_d_r[1] : rd_d_r[0];
         dq_oe_r <= (cl3 ? rd_v_r[1] : rd_v_r[0]) && !dqm_d1_r;
      end
   end

   // ----------------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------------
   always_comb begin
      apb_setup = psel && !penable && !pready_r;
      unique case (paddr)
         sctm_pkg::CTRL_OFF: rd_mux = {28'h0, ctrl_r};
         sctm_pkg::STAT_OFF: rd_mux = {25'h0, pwr_r, bank_open_r};
         sctm_pkg::ERR_OFF: rd_mux = {29'h0, err_r};
         default: rd_mux = 32'h0;
      endcase
   end

   // zero wait states: answer is ready during the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0;
      end else if (clk_en) begin
         pready_r <= apb_setup;
         pslverr_r <= apb_setup && (paddr != sctm_pkg::CTRL_OFF) &&
                      (paddr != sctm_pkg::STAT_OFF) && (paddr != sctm_pkg::ERR_OFF);
         if (apb_setup && !pwrite) begin
            prdata_r <= rd_mux;
         end
      end
   end

   // control register write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= sctm_pkg::CTRL_RST;
      end else if (clk_en && psel && penable && pready_r && pwrite &&
                   paddr == sctm_pkg::CTRL_OFF) begin
         ctrl_r <= pwdata[3:0];
      end
   end

   // misuse flags: a new event wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_r <= 3'h0;
      end else if (clk_en) begin
         err_r <= (err_r & ~((psel && penable && pready_r && pwrite &&
                              paddr == sctm_pkg::ERR_OFF) ? pwdata[2:0] : 3'h0)) |
                  {cmd_live && (mode_gap_r != 2'h0) && (cmd != sctm_pkg::CMD_NOP),
                   is_ref && (bank_open_r != 4'h0),
                   is_mode && (bank_open_r != 4'h0)};
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign dq_out = dq_out_r;
   assign dq_oe = dq_oe_r;
   assign bank_open = bank_open_r;
   assign power_state = pwr_r;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   mode_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
      is_mode && clk_en |=> !cmd_ok) else $error("command taken inside mode gap");
   refresh_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
      is_ref && clk_en |=> bank_open_r == 4'h0) else $error("refresh left a bank open");
   bank_map_a: assert property (@(posedge pclk) disable iff (!presetn)
      is_act && clk_en && !is_ref |=> bank_open_r[{$past(memory_group_select[0]),
      $past(memory_group_select[1])}]) else $error("activate opened wrong bank");
   pre_all_a: assert property (@(posedge pclk) disable iff (!presetn)
      is_pre && precharge_all_flag && clk_en |=> bank_open_r == 4'h0)
      else $error("precharge all left a bank open");
   stop_burst_a: assert property (@(posedge pclk) disable iff (!presetn)
      is_stop && clk_en |=> bst_left_r == 9'h000) else $error("burst stop ignored");
   wr_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_take && data_mask && clk_en |=> mem_r[$past(col_idx)] == $past(mem_r[col_idx]))
      else $error("masked write word stored");
   rd_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
      data_mask && clk_en ##1 clk_en |=> !dq_oe_r) else $error("masked read word driven");
   trail_cl3_a: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_req && cl3 && clk_en) ##1 (clk_en && !data_mask) ##1 (clk_en && !data_mask)
      |=> dq_oe_r) else $error("fetched read word not driven");
   deselect_a: assert property (@(posedge pclk) disable iff (!presetn)
      device_select_n && clk_en && !bst_on |=> $stable(bank_open_r))
      else $error("deselected command acted on");
   suspend_a: assert property (@(posedge pclk) disable iff (!presetn)
      cke_prev_r && !clock_gate && clk_en && bank_open_r != 4'h0
      |=> pwr_r == sctm_pkg::PWR_SUSPEND) else $error("suspend not entered");

endmodule : sctm_core

/* File: sctm_host.sv */
// sctm_host: host side model that turns a command code into the memory strobes
// assumes the bench spaces commands and changes them right after a rising edge
`timescale 1ns/1ps
module sctm_host (
   input wire sctm_pkg::sctm_cmd_t cmd,
   input wire logic desel,
   output logic ds_n,
   output logic [2:0] rcw_n
);
   // strobe pattern per command: row, column, write order
   always_comb begin
      ds_n = desel;
      case (cmd)
         sctm_pkg::CMD_MODE: rcw_n = 3'h0;
         sctm_pkg::CMD_ACT: rcw_n = 3'h3;
         sctm_pkg::CMD_READ: rcw_n = 3'h5;
         sctm_pkg::CMD_WRITE: rcw_n = 3'h4;
         sctm_pkg::CMD_STOP: rcw_n = 3'h6;
         sctm_pkg::CMD_PRE: rcw_n = 3'h2;
         sctm_pkg::CMD_REF: rcw_n = 3'h1;
         default: rcw_n = 3'h7; // no operation
      endcase
   end
endmodule : sctm_host

/* File: sdram_command_timing_bench.sv */
// sdram_command_timing_bench: self-checking bench for sctm_core
// assumes sctm_pkg and sctm_host are compiled first
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("wrong value t=%0t got=%0h exp=%0h", $time, g, e); end end
module sdram_command_timing_bench;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0] paddr = 8'h00, addr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, lf = 32'h1670;
   logic pready, pslverr, er, ds_n, cg = 1'h1, dm = 1'h0, apf = 1'h0, desel = 1'h0, oe;
   logic [2:0] rcw_n, ps;
   logic [1:0] sel = 2'h0;
   logic [15:0] dqi = 16'h0, dqo;
   logic [15:0] mem [4]; // expected storage of bank A columns
   logic [3:0] bo, ex = 4'h0;
   sctm_pkg::sctm_cmd_t cmd = sctm_pkg::CMD_NOP;
   int num_errors = 0, n_checks = 0;
   always #10 pclk = ~pclk;
   sctm_host host (.cmd(cmd), .desel(desel), .ds_n(ds_n), .rcw_n(rcw_n));
   sctm_core dut (.pclk(pclk), .presetn(presetn), .clk_en(1'h1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .device_select_n(ds_n), .row_strobe_n(rcw_n[2]),
      .column_strobe_n(rcw_n[1]), .write_strobe_n(rcw_n[0]), .clock_gate(cg),
      .data_mask(dm), .memory_group_select(sel), .precharge_all_flag(apf),
      .address(addr), .dq_in(dqi), .dq_out(dqo), .dq_oe(oe), .bank_open(bo),
      .power_state(ps));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   // one apb transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   // one command held for one edge; returns just after the edge that takes it
   task automatic issue(input sctm_pkg::sctm_cmd_t c, input logic [1:0] s, input logic ap,
      input logic [7:0] col, input logic [15:0] d, input logic m);
      @(posedge pclk);
      cmd <= c;
      sel <= s;
      apf <= ap;
      addr <= col;
      dqi <= d;
      dm <= m;
      @(posedge pclk);
      cmd <= sctm_pkg::CMD_NOP;
      dm <= 1'h0;
      #1;
   endtask : issue
   task automatic end_sim;
      if (num_errors == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_sim
   // watchdog cuts a hang short
   initial begin
      #100000;
      num_errors++;
      end_sim();
   end
   // main sequence
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, 8'h0C, 32'h0);
      `CHK({er, rd}, 33'h100000000) // unmapped offset refused
      for (int i = 0; i < 4; i++) begin
         issue(sctm_pkg::CMD_ACT, i[1:0], 1'h0, 8'h00, 16'h0, 1'h0);
         ex = ex | (4'h1 << {i[0], i[1]});
         `CHK(bo, ex)
      end
      @(posedge pclk);
      issue(sctm_pkg::CMD_PRE, 2'h3, 1'h0, 8'h00, 16'h0, 1'h0);
      `CHK(bo, 4'h7)
      apb(1'h1, sctm_pkg::CTRL_OFF, 32'h1);
      // single word writes; the last rewrites column 0 under mask
      for (int i = 0; i < 5; i++) begin
         lf = lfsr(lf);
         issue(sctm_pkg::CMD_WRITE, 2'h0, 1'h0, 8'(i % 4), lf[15:0], i == 4);
         if (i < 4)
            mem[i] = lf[15:0];
      end
      apb(1'h1, sctm_pkg::CTRL_OFF, 32'h5);
      issue(sctm_pkg::CMD_READ, 2'h0, 1'h0, 8'h00, 16'h0, 1'h0);
      // burst of four at latency 3, mask raised so word 1 is blanked
      for (int i = 0; i < 6; i++) begin
         @(posedge pclk);
         dm <= (i == 0);
         #1;
         if (i > 0) `CHK(oe, 1'(i != 2 && i != 5))
         if (i > 0 && i != 2 && i < 5) `CHK(dqo, mem[i - 1])
      end
      issue(sctm_pkg::CMD_PRE, 2'h1, 1'h1, 8'h00, 16'h0, 1'h0);
      `CHK(bo, 4'h0)
      // activate one cycle after mode load must be dropped
      @(posedge pclk);
      cmd <= sctm_pkg::CMD_MODE;
      @(posedge pclk);
      cmd <= sctm_pkg::CMD_ACT;
      @(posedge pclk);
      cmd <= sctm_pkg::CMD_NOP;
      #1;
      `CHK(bo, 4'h0)
      issue(sctm_pkg::CMD_ACT, 2'h0, 1'h0, 8'h00, 16'h0, 1'h0);
      `CHK(bo, 4'h1)
      apb(1'h0, sctm_pkg::ERR_OFF, 32'h0);
      `CHK(rd[2], 1'h1)
      // latency 2, full page read cut by burst stop: one trailing word
      apb(1'h1, sctm_pkg::CTRL_OFF, 32'hE);
      issue(sctm_pkg::CMD_READ, 2'h0, 1'h0, 8'h00, 16'h0, 1'h0);
      for (int i = 1; i < 5; i++) begin
         @(posedge pclk);
         cmd <= (i == 1) ? sctm_pkg::CMD_STOP : sctm_pkg::CMD_NOP;
         #1;
         `CHK(oe, 1'(i < 3))
         if (i < 3) `CHK(dqo, mem[i - 1])
      end
      // single word write with auto-precharge closes bank A at once
      apb(1'h1, sctm_pkg::CTRL_OFF, 32'h1);
      issue(sctm_pkg::CMD_WRITE, 2'h0, 1'h1, 8'h04, lf[31:16], 1'h0);
      `CHK(bo, 4'h0)
      repeat (2) @(posedge pclk);
      issue(sctm_pkg::CMD_ACT, 2'h0, 1'h0, 8'h00, 16'h0, 1'h0);
      `CHK(bo, 4'h1)
      // deselected precharge ignored, then suspend; selected precharge, then power-down
      for (int k = 0; k < 2; k++) begin
         @(posedge pclk);
         desel <= (k == 0);
         issue(sctm_pkg::CMD_PRE, 2'h0, 1'h1, 8'h00, 16'h0, 1'h0);
         `CHK(bo, 4'(k == 0))
         @(posedge pclk);
         cg <= 1'h0;
         @(posedge pclk);
         #1;
         `CHK(ps, 3'(2 << k))
         @(posedge pclk);
         cg <= 1'h1;
         @(posedge pclk);
         #1;
         `CHK(ps, 3'h1)
      end
      // refresh with every bank idle leaves them all closed
      issue(sctm_pkg::CMD_REF, 2'h0, 1'h0, 8'h00, 16'h0, 1'h0);
      `CHK(bo, 4'h0)
      end_sim();
   end
endmodule : sdram_command_timing_bench
